// >>> rtl/mrx_regs.svh
// register offsets, field positions, reset values and timing figures
`ifndef MRX_REGS_SVH
`define MRX_REGS_SVH
// =====================================================
// register offsets on the byte bus
`define OFS_SRC        6'h00
`define OFS_EN         6'h01
`define OFS_STAT       6'h02
`define OFS_CORR_FIRST 6'h20
`define OFS_CORR_NEXT  6'h21
// =====================================================
// field positions
`define SRC_RX         0
`define SRC_ROW1       1
`define SRC_LOSS       2
`define SRC_CORR2      3
`define ST_FRAME_GROUP_CHANGE       0
`define ST_GRP_LO      1
`define ST_BSYNC       3
`define ST_PARITY      4
`define ST_FSYNC       5
`define ST_CRC         6
`define ST_REAL        7
`define CORR_COLUMN    0
// =====================================================
// reset values
`define SRC_RST        4'h0
`define EN_RST         4'h0
`define STAT_RST       8'h00
// =====================================================
// timing figures
`define CLK_NS         25
`define T_ROW_OK_NS    138000
`define T_ROW_ERR_NS   274000
`define T_COL_OK_NS    1090000
`define T_COL_ERR_NS   2178000
`define LOSS_BLKS_NUM  272
`define LOSS_BLKS_DEN  4
`define LOSS_BLKS_ADD  123
`define FIRST_DATA_IDX 6'h01
`endif

// >>> rtl/mrx_pkg.sv
// types shared by the multiplex receive interrupt and status logic
package mrx_pkg;
    // framing method of the receiver
    typedef enum logic [1:0] {
        METH_B  = 2'b00,
        METH_A0 = 2'b01,
        METH_A1 = 2'b10
    } method_t;

    // description of the byte now coming from the receiver
    typedef struct packed {
        logic [8:0] blk_num;
        logic [5:0] byte_idx;
        logic       parity;
        logic       crc_err;
        logic       real_blk;
        method_t    method;
    } blk_info_t;

    // correction timer phases
    typedef enum logic [1:0] {
        CT_IDLE = 2'b00,
        CT_RUN  = 2'b01
    } corr_state_t;
endpackage

// >>> rtl/mrx_irq_status.sv
// interrupt flags, enable and block status of the multiplex receiver
`timescale 1ns/100ps
`default_nettype none
`include "mrx_regs.svh"

module mrx_irq_status #(
    parameter int ROW_OK_CYC  = `T_ROW_OK_NS / `CLK_NS,
    parameter int ROW_ERR_CYC = `T_ROW_ERR_NS / `CLK_NS,
    parameter int COL_OK_CYC  = `T_COL_OK_NS / `CLK_NS,
    parameter int COL_ERR_CYC = `T_COL_ERR_NS / `CLK_NS
) (
    input  wire logic               CORE_CLK,
    input  wire logic               SYS_RST,
    input  wire logic               CLEAR_PIN_N,
    input  wire logic               CS_N,
    input  wire logic               WR_N,
    input  wire logic               RD_N,
    input  wire logic [5:0]         ADDR,
    input  wire logic [7:0]         DB_IN,
    output var  logic [7:0]         DB_OUT,
    output var  logic               DB_OE,
    input  wire logic               BLOCK_DONE,
    input  wire logic               BYTE_STB,
    input  wire mrx_pkg::blk_info_t BLK,
    input  wire logic               FRAME_SYNC,
    input  wire logic               BLOCK_SYNC,
    input  wire logic               BLOCK_TICK,
    input  wire logic [3:0]         FWD_STEPS,
    input  wire logic               CORR_HAS_ERR,
    output var  logic               IRQ_N
);
    import mrx_pkg::*;

    localparam int TW = 17;

    // =====================================================
    // elaboration checks
    if (ROW_OK_CYC < 1 || ROW_ERR_CYC < 1 || COL_OK_CYC < 1 || COL_ERR_CYC < 1) begin : g_low
        $error("correction times must be at least one cycle");
    end
    if (COL_ERR_CYC >= (1 << TW) || COL_OK_CYC >= (1 << TW)) begin : g_high
        $error("correction times exceed timer width");
    end

    // =====================================================
    // pin synchronisers
    logic [17:0] pin_s1_ff;
    logic [17:0] pin_s2_ff;
    logic [17:0] pin_raw;

    assign pin_raw = {CLEAR_PIN_N, CS_N, WR_N, RD_N, ADDR, DB_IN};

    // two stages, second stage is the only reader of the first
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_s1_ff <= 18'h3F000;
            pin_s2_ff <= 18'h3F000;
        end else begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    logic       clr_n_s;
    logic       cs_s;
    logic       wr_s;
    logic       rd_s;
    logic [5:0] addr_s;
    logic [7:0] data_s;

    assign clr_n_s = pin_s2_ff[17];
    assign cs_s    = ~pin_s2_ff[16];
    assign wr_s    = ~pin_s2_ff[15];
    assign rd_s    = ~pin_s2_ff[14];
    assign addr_s  = pin_s2_ff[13:8];
    assign data_s  = pin_s2_ff[7:0];

    // =====================================================
    // write capture: sample while strobe low, commit at its end
    logic       wr_act_ff;
    logic [5:0] waddr_ff;
    logic [7:0] wdata_ff;
    logic       wr_commit;

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_act_ff <= 1'b0;
            waddr_ff  <= 6'h00;
            wdata_ff  <= 8'h00;
        end else begin
            wr_act_ff <= cs_s & wr_s;
            if (cs_s & wr_s) begin
                waddr_ff <= addr_s;
                wdata_ff <= data_s;
            end
        end
    end

    assign wr_commit = wr_act_ff & ~(cs_s & wr_s);

    logic wr_src;
    logic wr_en;
    logic wr_c1;
    logic wr_c2;

    // address decode of committed writes
    always_comb begin
        wr_src = 1'b0;
        wr_en  = 1'b0;
        wr_c1  = 1'b0;
        wr_c2  = 1'b0;
        if (!wr_commit) begin
            wr_src = 1'b0;
        end else if (waddr_ff == `OFS_SRC) begin
            wr_src = 1'b1;
        end else if (waddr_ff == `OFS_EN) begin
            wr_en = 1'b1;
        end else if (waddr_ff == `OFS_CORR_FIRST) begin
            wr_c1 = 1'b1;
        end else if (waddr_ff == `OFS_CORR_NEXT) begin
            wr_c2 = 1'b1;
        end
    end

    // =====================================================
    // correction timers
    logic [TW-1:0] tmr1_ff;
    logic [TW-1:0] tmr2_ff;
    logic [TW-1:0] nxt_tmr2;
    corr_state_t   ct1_ff;
    corr_state_t   ct2_ff;
    logic          done1;
    logic          done2;

    // second stage length by direction and error presence
    always_comb begin
        if (wdata_ff[`CORR_COLUMN]) begin
            nxt_tmr2 = CORR_HAS_ERR ? TW'(COL_ERR_CYC) : TW'(COL_OK_CYC);
        end else begin
            nxt_tmr2 = CORR_HAS_ERR ? TW'(ROW_ERR_CYC) : TW'(ROW_OK_CYC);
        end
    end

    assign done1 = (ct1_ff == CT_RUN) && (tmr1_ff == TW'(1));
    assign done2 = (ct2_ff == CT_RUN) && (tmr2_ff == TW'(1));

    // first row correction countdown
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ct1_ff  <= CT_IDLE;
            tmr1_ff <= '0;
        end else begin
            case (ct1_ff)
                CT_IDLE: begin
                    if (wr_c1) begin
                        ct1_ff  <= CT_RUN;
                        tmr1_ff <= TW'(ROW_ERR_CYC);
                    end
                end
                CT_RUN: begin
                    tmr1_ff <= tmr1_ff - TW'(1);
                    if (done1) begin
                        ct1_ff <= CT_IDLE;
                    end
                end
                default: ct1_ff <= CT_IDLE;
            endcase
        end
    end

    // column or second row countdown
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ct2_ff  <= CT_IDLE;
            tmr2_ff <= '0;
        end else begin
            case (ct2_ff)
                CT_IDLE: begin
                    if (wr_c2) begin
                        ct2_ff  <= CT_RUN;
                        tmr2_ff <= nxt_tmr2;
                    end
                end
                CT_RUN: begin
                    tmr2_ff <= tmr2_ff - TW'(1);
                    if (done2) begin
                        ct2_ff <= CT_IDLE;
                    end
                end
                default: ct2_ff <= CT_IDLE;
            endcase
        end
    end

    // =====================================================
    // frame sync loss watch in block periods
    logic        fs_seen_ff;
    logic [10:0] loss_cnt_ff;
    logic [10:0] loss_lim;
    logic        loss_hit;

    assign loss_lim = 11'(`LOSS_BLKS_NUM / `LOSS_BLKS_DEN) * 11'(FWD_STEPS)
                    + 11'(`LOSS_BLKS_ADD);
    assign loss_hit = fs_seen_ff && !FRAME_SYNC && BLOCK_TICK
                    && (loss_cnt_ff + 11'h001 == loss_lim);

    // count block periods without frame sync once sync was held
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            fs_seen_ff  <= 1'b0;
            loss_cnt_ff <= 11'h000;
        end else if (FRAME_SYNC) begin
            fs_seen_ff  <= 1'b1;
            loss_cnt_ff <= 11'h000;
        end else if (loss_hit) begin
            fs_seen_ff  <= 1'b0;
            loss_cnt_ff <= 11'h000;
        end else if (fs_seen_ff && BLOCK_TICK) begin
            loss_cnt_ff <= loss_cnt_ff + 11'h001;
        end
    end

    // =====================================================
    // source flags, enable and request
    logic [3:0] src_ff;
    logic [3:0] en_ff;
    logic [3:0] set_evt;
    logic       rx_ok;

    assign rx_ok   = BLOCK_DONE & (FRAME_SYNC | BLOCK_SYNC);
    assign set_evt = {done2, loss_hit, done1, rx_ok};

    // sticky flags: set beats write clear and pin clear
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            src_ff <= `SRC_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (set_evt[i]) begin
                    src_ff[i] <= 1'b1;
                end else if (!clr_n_s) begin
                    src_ff[i] <= 1'b0;
                end else if (wr_src && wdata_ff[i]) begin
                    src_ff[i] <= 1'b0;
                end
            end
        end
    end

    // enable register, write only
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            en_ff <= `EN_RST;
        end else if (wr_en) begin
            en_ff <= wdata_ff[3:0];
        end
    end

    // request pin, low while an enabled flag stands
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            IRQ_N <= 1'b1;
        end else begin
            IRQ_N <= ~|(src_ff & en_ff);
        end
    end

    // =====================================================
    // received block status
    logic [7:0] stat_ff;
    logic [1:0] grp;
    logic       grp_start;
    logic [8:0] bn;

    assign bn = BLK.blk_num;

    // block group and group start by framing method
    always_comb begin
        grp       = 2'b00;
        grp_start = 1'b0;
        if (BLK.method == METH_B) begin
            if (bn >= 9'h0BF) begin
                grp = 2'b11;
            end else if (bn >= 9'h083) begin
                grp = 2'b10;
            end else if (bn >= 9'h03D) begin
                grp = 2'b01;
            end
            grp_start = (bn == 9'h001) || (bn == 9'h03D) || (bn == 9'h083) || (bn == 9'h0BF);
        end else begin
            if (bn >= 9'h096) begin
                grp = 2'b11;
            end else if (bn >= 9'h089) begin
                grp = 2'b10;
            end else if (bn >= 9'h00E) begin
                grp = 2'b01;
            end
            grp_start = (bn == 9'h001) || (bn == 9'h00E) || (bn == 9'h089) || (bn == 9'h096);
        end
    end

    // status follows each received byte, host cannot write it
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            stat_ff <= `STAT_RST;
        end else if (BYTE_STB) begin
            stat_ff[`ST_FRAME_GROUP_CHANGE]  <= grp_start && (BLK.byte_idx == `FIRST_DATA_IDX);
            stat_ff[2:1]        <= grp;
            stat_ff[`ST_BSYNC]  <= BLOCK_SYNC;
            stat_ff[`ST_PARITY] <= BLK.parity & FRAME_SYNC;
            stat_ff[`ST_FSYNC]  <= FRAME_SYNC;
            stat_ff[`ST_CRC]    <= BLK.crc_err;
            stat_ff[`ST_REAL]   <= BLK.real_blk & FRAME_SYNC & (BLK.method != METH_B);
        end
    end

    // =====================================================
    // read path
    logic [7:0] rd_mux;

    // readable registers, all others read zero
    always_comb begin
        rd_mux = 8'h00;
        if (addr_s == `OFS_SRC) begin
            rd_mux = {4'h0, src_ff};
        end else if (addr_s == `OFS_STAT) begin
            rd_mux = stat_ff;
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            DB_OUT <= 8'h00;
            DB_OE  <= 1'b0;
        end else begin
            DB_OUT <= rd_mux;
            DB_OE  <= cs_s & rd_s;
        end
    end

    // =====================================================
    // assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    a_rx_flag_set: assert property (rx_ok |=> src_ff[0])
        else $error("receive flag not set");
    a_w1c_clear: assert property (wr_src && wdata_ff[0] && !set_evt[0] |=> !src_ff[0])
        else $error("write of one did not clear");
    a_w1c_keep: assert property (wr_src && !wdata_ff[1] && src_ff[1] && clr_n_s
        |=> src_ff[1])
        else $error("write of zero changed a flag");
    a_row1_load: assert property (ct1_ff == CT_IDLE && wr_c1
        |=> ct1_ff == CT_RUN && tmr1_ff == TW'(ROW_ERR_CYC))
        else $error("first row timer not loaded");
    a_row1_done: assert property (done1 |=> src_ff[1] && ct1_ff == CT_IDLE)
        else $error("first row flag late");
    a_corr2_time: assert property (ct2_ff == CT_IDLE && wr_c2 && wdata_ff[0] && !CORR_HAS_ERR
        |=> tmr2_ff == TW'(COL_OK_CYC))
        else $error("column time wrong");
    a_loss_cause: assert property ($rose(src_ff[2]) |-> $past(loss_hit))
        else $error("sync loss flag without cause");
    a_irq_follow: assert property (|(src_ff & en_ff) |=> !IRQ_N)
        else $error("request not raised");
    a_irq_quiet: assert property (!(|(src_ff & en_ff)) |=> IRQ_N)
        else $error("request without enabled flag");
    a_stat_parity: assert property (stat_ff[`ST_PARITY] |-> stat_ff[`ST_FSYNC])
        else $error("parity shown out of frame sync");
    a_en_write: assert property (wr_en |=> en_ff == $past(wdata_ff[3:0]))
        else $error("enable not written");

    c_rx_flag: cover property (rx_ok ##1 wr_src);
    c_loss: cover property (loss_hit);
    c_col_err: cover property (ct2_ff == CT_RUN && tmr2_ff == TW'(COL_ERR_CYC));
    c_pin_clear: cover property (!clr_n_s && src_ff[0]);

endmodule
`default_nettype wire

// >>> test/mrx_host_model.sv
// host microcontroller model driving the byte-wide register bus
`timescale 1ns/100ps
`default_nettype none

module mrx_host_model (
    input  wire logic       clk,
    output var  logic       cs_n,
    output var  logic       wr_n,
    output var  logic       rd_n,
    output var  logic [5:0] addr,
    output var  logic [7:0] db_in,
    input  wire logic [7:0] db_out,
    input  wire logic       db_oe
);
    logic [7:0] float_q;
    logic [7:0] bus;

    // idle bus at time zero
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        addr = 6'h3F;
        db_in = 8'h00;
        float_q = 8'h5A;
    end

    // undriven data bus wanders every cycle
    always @(posedge clk) begin
        float_q <= ~float_q;
    end
    assign bus = db_oe ? db_out : float_q;

    // write cycle: strobes low four cycles, then high five; host clears flags this way
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        addr <= a;
        db_in <= d;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        addr <= ~a;
        db_in <= ~d;
        repeat (5) @(posedge clk);
    endtask

    // read cycle: data taken at the edge ending the strobe
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        repeat (4) @(posedge clk);
        d = bus;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        addr <= ~a;
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the receiver interrupt and status block
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import mrx_pkg::*;
    localparam int P_ROK = 5;
    localparam int P_RERR = 10;
    localparam int P_COK = 20;
    localparam int P_CERR = 40;

    logic            core_clk;
    logic            sys_rst;
    logic            clear_pin_n;
    logic            cs_n;
    logic            wr_n;
    logic            rd_n;
    logic [5:0]      addr;
    logic [7:0]      db_in;
    logic [7:0]      db_out;
    logic            db_oe;
    logic            block_done;
    logic            byte_stb;
    blk_info_t       blk;
    logic            frame_sync;
    logic            block_sync;
    logic            block_tick;
    logic [3:0]      fwd_steps;
    logic            corr_has_err;
    logic            irq_n;
    int              num_errors;
    int              cmp_count;
    logic [7:0]      rv;
    int              d0;
    int              dn;

    // ==========================================
    // design and host model
    mrx_irq_status #(.ROW_OK_CYC(P_ROK), .ROW_ERR_CYC(P_RERR),
        .COL_OK_CYC(P_COK), .COL_ERR_CYC(P_CERR)) i_dut (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLEAR_PIN_N(clear_pin_n),
        .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n), .ADDR(addr), .DB_IN(db_in),
        .DB_OUT(db_out), .DB_OE(db_oe), .BLOCK_DONE(block_done),
        .BYTE_STB(byte_stb), .BLK(blk), .FRAME_SYNC(frame_sync),
        .BLOCK_SYNC(block_sync), .BLOCK_TICK(block_tick), .FWD_STEPS(fwd_steps),
        .CORR_HAS_ERR(corr_has_err), .IRQ_N(irq_n));
    mrx_host_model i_host (.clk(core_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .addr(addr), .db_in(db_in), .db_out(db_out), .db_oe(db_oe));

    // ==========================================
    // clock, checks and verdict
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one-cycle pulse on block tick (1) or block done (0)
    task automatic pulse(input logic tick);
        @(posedge core_clk);
        if (tick) begin
            block_tick <= 1'b1;
        end else begin
            block_done <= 1'b1;
        end
        @(posedge core_clk);
        block_tick <= 1'b0;
        block_done <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // cycles from end of a start write until the request goes low
    task automatic corr(input logic [5:0] a, input logic [7:0] d, input logic e,
                        input logic [7:0] f, output int n);
        corr_has_err <= e;
        i_host.wr(a, d);
        n = 0;
        while (irq_n !== 1'b0 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        i_host.rd(6'h00, rv);
        check("corr flag", rv, f);
        i_host.wr(6'h00, 8'h0F);
    endtask

    // one received byte described to the status register
    task automatic byte_in(input method_t m, input logic [8:0] bn, input logic [5:0] bi,
                           input logic [4:0] fl, input logic [7:0] exp);
        @(posedge core_clk);
        {frame_sync, block_sync} <= fl[4:3];
        blk <= '{blk_num: bn, byte_idx: bi, parity: fl[2], crc_err: fl[1],
                 real_blk: fl[0], method: m};
        byte_stb <= 1'b1;
        @(posedge core_clk);
        byte_stb <= 1'b0;
        i_host.rd(6'h02, rv);
        check("status", rv, exp);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        final_report();
    end

    // ==========================================
    // main sequence
    initial begin
        num_errors = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        clear_pin_n = 1'b1;
        block_done = 1'b0;
        byte_stb = 1'b0;
        blk = '0;
        frame_sync = 1'b0;
        block_sync = 1'b0;
        block_tick = 1'b0;
        fwd_steps = 4'h1;
        corr_has_err = 1'b0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        // reset values, write-only and unmapped reads
        i_host.rd(6'h00, rv);
        check("source reset", rv, 8'h00);
        i_host.rd(6'h01, rv);
        check("enable read", rv, 8'h00);
        i_host.rd(6'h02, rv);
        check("status reset", rv, 8'h00);
        i_host.rd(6'h3F, rv);
        check("unmapped", rv, 8'h00);
        // block received only while synchronised
        pulse(1'b0);
        i_host.rd(6'h00, rv);
        check("no rx out of sync", rv, 8'h00);
        frame_sync <= 1'b1;
        pulse(1'b0);
        i_host.rd(6'h00, rv);
        check("rx flag", rv, 8'h01);
        check("irq masked", 8'(irq_n), 8'h01);
        i_host.wr(6'h01, 8'h0F);
        check("irq enabled", 8'(irq_n), 8'h00);
        i_host.wr(6'h00, 8'h0E);
        check("zero keeps", 8'(irq_n), 8'h00);
        i_host.wr(6'h00, 8'h01);
        check("one clears", 8'(irq_n), 8'h01);
        // correction timers, differences remove fixed latency
        corr(6'h21, 8'h00, 1'b0, 8'h08, d0);
        corr(6'h20, 8'h00, 1'b0, 8'h02, dn);
        check("first row", 8'(dn - d0), 8'(P_RERR - P_ROK));
        corr(6'h21, 8'h00, 1'b1, 8'h08, dn);
        check("row err", 8'(dn - d0), 8'(P_RERR - P_ROK));
        corr(6'h21, 8'h01, 1'b0, 8'h08, dn);
        check("col ok", 8'(dn - d0), 8'(P_COK - P_ROK));
        corr(6'h21, 8'h01, 1'b1, 8'h08, dn);
        check("col err", 8'(dn - d0), 8'(P_CERR - P_ROK));
        // clear pin
        pulse(1'b0);
        check("flag before pin", 8'(irq_n), 8'h00);
        @(posedge core_clk);
        clear_pin_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        clear_pin_n <= 1'b1;
        i_host.rd(6'h00, rv);
        check("pin clear", rv, 8'h00);
        // status register: method, block, index, {fs, bs, par, crc, real}
        byte_in(METH_A0, 9'h00E, 6'h01, 5'h1D, 8'hBB);
        byte_in(METH_B, 9'h0BF, 6'h02, 5'h0F, 8'h4E);
        byte_in(METH_A1, 9'h11C, 6'h01, 5'h11, 8'hA6);
        byte_in(METH_B, 9'h03D, 6'h01, 5'h19, 8'h2B);
        byte_in(METH_B, 9'h089, 6'h01, 5'h18, 8'h2C);
        i_host.wr(6'h02, 8'hFF);
        i_host.rd(6'h02, rv);
        check("status ro", rv, 8'h2C);
        // sync loss after 68*1+123 block periods
        frame_sync <= 1'b1;
        repeat (3) @(posedge core_clk);
        frame_sync <= 1'b0;
        repeat (190) pulse(1'b1);
        check("no loss yet", 8'(irq_n), 8'h01);
        pulse(1'b1);
        i_host.rd(6'h00, rv);
        check("loss flag", rv, 8'h04);
        final_report();
    end
endmodule
`default_nettype wire
